// file: core/serial_eeprom_program_cmds.sv
`timescale 1ns/1ns
// Behaviour
// - frame: select rise, start one, opcode, address
// - opcode 00: address top bits pick special
// - programming disabled after reset
// - enable persists until disable or reset
// - disable blocks all four programming commands
// - reads work whether enabled or not
// - erase sets addressed word to all ones
// - erase cycle starts once address decoded
// - status driven after select low then high
// - output high after erase means ready
// - write carries one sixteen bit word
// - program cycle starts after last data bit
// - output low while program cycle runs
// - output high once word stored, ready
// - no status needed if raised after completion
// - bulk fill writes word into every location
// - bulk erase sets whole array to ones
module serial_eeprom_program_cmds #(
  parameter int PROG_CYCLES = eeprom_pkg::PROGRAM_CYCLE_CYCLES
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  // serial pins from the host
  input  wire logic chip_select_i,
  input  wire logic serial_clock_pin_i,
  input  wire logic serial_in_pin_i,
  // serial output pin
  output logic      serial_out_o,
  output logic      serial_out_oe_o
);

  // ==========================================================================
  // pin synchronisers: bit 0 select, bit 1 clock, bit 2 data
  logic [2:0] sync1, sync2, sync3;         // three flop chain
  logic [2:0] filt, filt_d;                // agreed level and its past
  logic [2:0] next_sync1, next_sync2, next_sync3;
  logic [2:0] next_filt, next_filt_d;

  // a change counts once the second and third stages agree
  always_comb begin
    next_sync1  = {serial_in_pin_i, serial_clock_pin_i, chip_select_i};
    next_sync2  = sync1;
    next_sync3  = sync2;
    next_filt_d = filt;
    next_filt   = filt;
    for (int i = 0; i < 3; i++) begin
      if (sync2[i] == sync3[i]) begin
        next_filt[i] = sync3[i];
      end
    end
  end

  // registers of the synchronisers
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1  <= eeprom_pkg::PIN_RESET;
      sync2  <= eeprom_pkg::PIN_RESET;
      sync3  <= eeprom_pkg::PIN_RESET;
      filt   <= eeprom_pkg::PIN_RESET;
      filt_d <= eeprom_pkg::PIN_RESET;
    end else begin
      sync1  <= next_sync1;
      sync2  <= next_sync2;
      sync3  <= next_sync3;
      filt   <= next_filt;
      filt_d <= next_filt_d;
    end
  end

  logic cs_hi, cs_fall, sk_rise, din;      // decoded pin events
  assign cs_hi   = filt[0];
  assign cs_fall = filt_d[0] & ~filt[0];
  assign sk_rise = filt[1] & ~filt_d[1];
  assign din     = filt[2];

  // ==========================================================================
  // serial frame decoder and read stream
  eeprom_pkg::link_state_e state, next_state;
  logic [1:0]  opcode, next_opcode;        // received opcode
  logic [7:0]  addr, next_addr;            // received address
  logic [15:0] data, next_data;            // received data word
  logic [3:0]  bit_cnt, next_bit_cnt;      // bits left in a field
  logic        enabled, next_enabled;      // programming allowed
  logic        status_arm, next_status_arm; // status shown on select high
  logic [7:0]  rd_addr, next_rd_addr;      // read pointer
  logic [15:0] shreg, next_shreg;          // read shift register
  logic        dout, next_dout;            // read data bit
  logic        next_sout, next_soe;        // pin output values
  logic        launch, launch_bulk;        // start of a program cycle
  logic [7:0]  launch_addr;                // target of a single write
  logic [15:0] launch_word;                // word to program
  logic [15:0] rd_data;                    // array read data
  logic [15:0] addr_shift;                 // address with next bit shifted in
  logic        busy;                       // program cycle running

  // shift one serial bit into the low end of a field
  function automatic logic [15:0] shift_in(input logic [15:0] v,
                                           input logic b);
    shift_in = {v[14:0], b};
  endfunction

  // next values of the frame decoder
  always_comb begin
    next_state      = state;
    next_opcode     = opcode;
    next_addr       = addr;
    next_data       = data;
    next_bit_cnt    = bit_cnt;
    next_enabled    = enabled;
    next_status_arm = status_arm;
    next_rd_addr    = rd_addr;
    next_shreg      = shreg;
    next_dout       = dout;
    launch          = 1'b0;
    launch_bulk     = 1'b0;
    launch_addr     = addr;
    launch_word     = eeprom_pkg::ERASED_WORD;
    addr_shift      = shift_in({8'h00, addr}, din);
    // arm status when select drops during a cycle, else drop it
    if (cs_fall) begin
      next_status_arm = busy;
    end
    if (!cs_hi) begin
      next_state = eeprom_pkg::ST_IDLE;
    end else if (sk_rise) begin
      case (state)
        // wait for the start bit; none is taken during a cycle
        eeprom_pkg::ST_IDLE: begin
          if (din && !busy) begin
            next_state      = eeprom_pkg::ST_OPCODE;
            next_bit_cnt    = 4'h1;
            next_status_arm = 1'b0;
          end
        end
        // two opcode bits
        eeprom_pkg::ST_OPCODE: begin
          next_opcode  = {opcode[0], din};
          next_bit_cnt = bit_cnt - 4'h1;
          if (bit_cnt == 4'h0) begin
            next_state   = eeprom_pkg::ST_ADDR;
            next_bit_cnt = 4'(eeprom_pkg::ADDR_W - 1);
          end
        end
        // address bits, don't care bits included
        eeprom_pkg::ST_ADDR: begin
          next_addr    = addr_shift[7:0];
          next_bit_cnt = bit_cnt - 4'h1;
          if (bit_cnt == 4'h0) begin
            next_state = eeprom_pkg::ST_HOLD;
            case (opcode)
              eeprom_pkg::OPC_READ: begin
                next_state   = eeprom_pkg::ST_READ;
                next_rd_addr = next_addr;
                next_dout    = 1'b0;
                next_bit_cnt = 4'h0;
              end
              eeprom_pkg::OPC_WRITE: begin
                next_state   = eeprom_pkg::ST_DATA;
                next_bit_cnt = 4'(eeprom_pkg::DATA_W - 1);
              end
              eeprom_pkg::OPC_ERASE: begin
                launch      = enabled;
                launch_addr = next_addr;
                launch_word = eeprom_pkg::ERASED_WORD;
              end
              default: begin
                case (next_addr[7:6])
                  eeprom_pkg::SPC_ENABLE: begin
                    next_enabled = 1'b1;
                  end
                  eeprom_pkg::SPC_DISABLE: begin
                    next_enabled = 1'b0;
                  end
                  eeprom_pkg::SPC_BULK_ERASE: begin
                    launch      = enabled;
                    launch_bulk = 1'b1;
                  end
                  default: begin
                    next_state   = eeprom_pkg::ST_DATA;
                    next_bit_cnt = 4'(eeprom_pkg::DATA_W - 1);
                  end
                endcase
              end
            endcase
          end
        end
        // data word of a write or bulk fill
        eeprom_pkg::ST_DATA: begin
          next_data    = shift_in(data, din);
          next_bit_cnt = bit_cnt - 4'h1;
          if (bit_cnt == 4'h0) begin
            next_state  = eeprom_pkg::ST_HOLD;
            launch      = enabled;
            launch_bulk = (opcode == eeprom_pkg::OPC_SPECIAL);
            launch_word = next_data;
          end
        end
        // read stream: load a word every sixteen bits
        eeprom_pkg::ST_READ: begin
          next_bit_cnt = bit_cnt - 4'h1;
          if (bit_cnt == 4'h0) begin
            next_dout    = rd_data[15];
            next_shreg   = {rd_data[14:0], 1'b0};
            next_rd_addr = rd_addr + 8'h01;
            next_bit_cnt = 4'hf;
          end else begin
            next_dout  = shreg[15];
            next_shreg = {shreg[14:0], 1'b0};
          end
        end
        // frame complete, wait for select low
        eeprom_pkg::ST_HOLD: begin
          next_state = eeprom_pkg::ST_HOLD;
        end
        default: begin
          next_state = eeprom_pkg::ST_IDLE;
        end
      endcase
    end
    // pin: ready/busy while armed, read data in a read, else released
    next_soe  = cs_hi && (status_arm || state == eeprom_pkg::ST_READ);
    next_sout = status_arm ? ~busy : dout;
    if (!cs_hi) begin
      next_soe = 1'b0;
    end
  end

  // registers of the frame decoder
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state           <= eeprom_pkg::ST_IDLE;
      opcode          <= 2'h0;
      addr            <= 8'h00;
      data            <= 16'h0000;
      bit_cnt         <= 4'h0;
      enabled         <= eeprom_pkg::ENABLE_RESET;
      status_arm      <= 1'b0;
      rd_addr         <= 8'h00;
      shreg           <= 16'h0000;
      dout            <= 1'b0;
      serial_out_o    <= 1'b0;
      serial_out_oe_o <= 1'b0;
    end else begin
      state           <= next_state;
      opcode          <= next_opcode;
      addr            <= next_addr;
      data            <= next_data;
      bit_cnt         <= next_bit_cnt;
      enabled         <= next_enabled;
      status_arm      <= next_status_arm;
      rd_addr         <= next_rd_addr;
      shreg           <= next_shreg;
      dout            <= next_dout;
      serial_out_o    <= next_sout;
      serial_out_oe_o <= next_soe;
    end
  end

  // ==========================================================================
  // self-timed program engine
  logic [17:0] timer, next_timer;          // cycles left in the cycle
  logic        next_busy;
  logic        fill_active, next_fill_active; // bulk pass running
  logic [7:0]  fill_ptr, next_fill_ptr;    // bulk pass address
  logic [15:0] fill_word, next_fill_word;  // bulk pass word
  logic        wr_en;                      // array write strobe
  logic [7:0]  wr_addr;                    // array write address
  logic [15:0] wr_data;                    // array write data

  // next values of the engine; busy covers timer and bulk pass
  always_comb begin
    next_busy        = busy;
    next_timer       = timer;
    next_fill_active = fill_active;
    next_fill_ptr    = fill_ptr;
    next_fill_word   = fill_word;
    wr_en            = 1'b0;
    wr_addr          = launch_addr;
    wr_data          = launch_word;
    if (launch) begin
      next_busy        = 1'b1;
      next_timer       = 18'(PROG_CYCLES - 1);
      next_fill_active = launch_bulk;
      next_fill_ptr    = 8'h00;
      next_fill_word   = launch_word;
      wr_en            = ~launch_bulk;
    end else if (busy) begin
      if (fill_active) begin
        wr_en         = 1'b1;
        wr_addr       = fill_ptr;
        wr_data       = fill_word;
        next_fill_ptr = fill_ptr + 8'h01;
        if (fill_ptr == 8'(eeprom_pkg::DEPTH - 1)) begin
          next_fill_active = 1'b0;
        end
      end
      if (timer != 18'h0_0000) begin
        next_timer = timer - 18'h0_0001;
      end else if (!fill_active) begin
        next_busy = 1'b0;
      end
    end
  end

  // registers of the engine
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy        <= 1'b0;
      timer       <= 18'h0_0000;
      fill_active <= 1'b0;
      fill_ptr    <= 8'h00;
      fill_word   <= 16'h0000;
    end else begin
      busy        <= next_busy;
      timer       <= next_timer;
      fill_active <= next_fill_active;
      fill_ptr    <= next_fill_ptr;
      fill_word   <= next_fill_word;
    end
  end

  // ==========================================================================
  // storage array
  eeprom_array u_array (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .wr_en_i   (wr_en),
    .wr_addr_i (wr_addr),
    .wr_data_i (wr_data),
    .rd_addr_i (rd_addr),
    .rd_data_o (rd_data)
  );

endmodule

// file: core/eeprom_pkg.sv
// ==========================================================================
// shared constants of the serial eeprom command logic
package eeprom_pkg;

  // array shape: word organization, 256 words of 16 bits
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int DEPTH  = 256;

  // opcodes that follow the start bit
  localparam logic [1:0] OPC_READ    = 2'h2;
  localparam logic [1:0] OPC_WRITE   = 2'h1;
  localparam logic [1:0] OPC_ERASE   = 2'h3;
  localparam logic [1:0] OPC_SPECIAL = 2'h0;

  // special command selected by the two leading address bits
  localparam logic [1:0] SPC_ENABLE     = 2'h3;
  localparam logic [1:0] SPC_BULK_ERASE = 2'h2;
  localparam logic [1:0] SPC_BULK_FILL  = 2'h1;
  localparam logic [1:0] SPC_DISABLE    = 2'h0;

  // value of an erased word
  localparam logic [15:0] ERASED_WORD = 16'hffff;

  // reset values
  localparam logic [2:0] PIN_RESET     = 3'h0;
  localparam logic       ENABLE_RESET  = 1'b0;

  // timing
  localparam int SYS_CLK_PERIOD_NS     = 20;
  localparam int PROGRAM_CYCLE_TIME_US = 5000;
  localparam int PROGRAM_CYCLE_CYCLES  =
    (PROGRAM_CYCLE_TIME_US * 1000) / SYS_CLK_PERIOD_NS;
  localparam int TIMER_W = 18;

  // serial frame states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPCODE,
    ST_ADDR,
    ST_DATA,
    ST_READ,
    ST_HOLD
  } link_state_e;

endpackage

// file: core/eeprom_array.sv
`timescale 1ns/1ns
// ==========================================================================
// storage array: one write port, one read port with registered data
module eeprom_array (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  // write port
  input  wire logic        wr_en_i,
  input  wire logic [7:0]  wr_addr_i,
  input  wire logic [15:0] wr_data_i,
  // read port
  input  wire logic [7:0]  rd_addr_i,
  output logic      [15:0] rd_data_o
);

  logic [15:0] cells [0:eeprom_pkg::DEPTH-1];  // cell contents, no reset

  // ==========================================================================
  // write port
  always_ff @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      cells[wr_addr_i] <= wr_data_i;
    end
  end

  // ==========================================================================
  // read port, data from a register
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_data_o <= 16'h0000;
    end else begin
      rd_data_o <= cells[rd_addr_i];
    end
  end

endmodule

// file: bench/serial_eeprom_properties.sv
`timescale 1ns/1ns
// ==========================================================================
// port checks of the serial eeprom command block
module serial_eeprom_checks #(
  parameter int PROG_CYCLES = 300
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // pins
  input wire logic chip_select_i,
  input wire logic serial_clock_pin_i,
  input wire logic serial_out_o,
  input wire logic serial_out_oe_o
);
  localparam int READY_MAX = PROG_CYCLES + 20;
  logic       sk_last;  // serial clock one cycle ago
  logic       sk_rise;  // serial clock rising now
  logic [9:0] since_sk; // cycles since a serial clock rise
  logic [9:0] since_cs; // cycles select has been high
  logic [9:0] cs_off;   // cycles select has been low
  logic [9:0] lo_run;   // cycles of a quiet low status
  logic [9:0] next_since_sk, next_since_cs, next_cs_off, next_lo_run;
  // saturating pin history counters
  always_comb begin
    sk_rise = serial_clock_pin_i && !sk_last;
    next_since_sk = sk_rise ? '0 : since_sk + {9'h000, &since_sk == 1'b0};
    next_since_cs = !chip_select_i ? '0 : since_cs + {9'h000, &since_cs == 1'b0};
    next_cs_off = chip_select_i ? '0 : cs_off + {9'h000, &cs_off == 1'b0};
    next_lo_run = '0;
    if (serial_out_oe_o && !serial_out_o && !sk_rise) begin
      next_lo_run = lo_run + {9'h000, &lo_run == 1'b0};
    end
  end
  // registers only
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sk_last  <= 1'b0;
      since_sk <= '0;
      since_cs <= '0;
      cs_off   <= '0;
      lo_run   <= '0;
    end else begin
      sk_last  <= serial_clock_pin_i;
      since_sk <= next_since_sk;
      since_cs <= next_since_cs;
      cs_off   <= next_cs_off;
      lo_run   <= next_lo_run;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  reset_quiet_a: assert property ($rose(rstn_i) |->
    !serial_out_oe_o && !serial_out_o) else $error("output active at reset");
  output_released_a: assert property (
    serial_out_oe_o |-> cs_off < 10'h008)
    else $error("output driven with select low");
  oe_select_a: assert property ($rose(serial_out_oe_o) |->
    chip_select_i && since_cs >= 10'h003) else $error("output without select");
  oe_drop_a: assert property ($fell(serial_out_oe_o) |->
    cs_off != '0 || since_sk < 10'h00c) else $error("status dropped early");
  oe_stands_a: assert property (
    serial_out_oe_o && since_cs > 10'h008 &&
    since_sk > 10'h00c |=> serial_out_oe_o) else $error("status not held");
  ready_only_a: assert property (
    serial_out_oe_o && $past(serial_out_oe_o)
    && since_sk > 10'h00c && $changed(serial_out_o) |-> serial_out_o)
    else $error("status fell back to busy");
  busy_bound_a: assert property (lo_run <= READY_MAX)
    else $error("busy too long");
  ready_time_a: assert property ($rose(serial_out_oe_o) &&
    since_sk > 10'h00c |-> ##[0:READY_MAX] (serial_out_o || !serial_out_oe_o))
    else $error("ready never shown");
  // main scenarios
  cover property ($rose(serial_out_oe_o) && !serial_out_o);
  cover property (serial_out_oe_o && $rose(serial_out_o) && since_sk > 10'h00c);
  cover property (serial_out_oe_o && since_sk < 10'h008);
endmodule
bind serial_eeprom_program_cmds serial_eeprom_checks #(
  .PROG_CYCLES(PROG_CYCLES)
) i_checks (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .chip_select_i(chip_select_i),
  .serial_clock_pin_i(serial_clock_pin_i), .serial_out_o(serial_out_o),
  .serial_out_oe_o(serial_out_oe_o)
);

// file: bench/eeprom_host_model.sv
`timescale 1ns/1ns
// ==========================================================================
// host controller on the three-wire bus, 160 ns serial clock
module eeprom_host_model (
  // clock
  input  wire logic sys_clk_i,
  // device output
  input  wire logic serial_out_i,
  // pins to the device
  output logic      chip_select_o,
  output logic      serial_clock_o,
  output logic      serial_in_o
);
  logic [15:0] rx; // last sixteen sampled output bits
  // pins idle low at time zero
  initial begin
    chip_select_o  = 1'b0;
    serial_clock_o = 1'b0;
    serial_in_o    = 1'b0;
    rx             = 16'h0000;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // change select, then keep it for at least the select-low minimum
  task automatic select(input logic lvl);
    @(posedge sys_clk_i);
    chip_select_o <= lvl;
    wait_clk(8);
  endtask
  // msb first: data set with clock low, output sampled before each rise
  task automatic shift(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge sys_clk_i);
      serial_in_o    <= v[i];
      serial_clock_o <= 1'b0;
      wait_clk(4);
      rx = {rx[14:0], serial_out_i};
      serial_clock_o <= 1'b1;
      wait_clk(3);
    end
  endtask
  // one framed instruction; hold keeps select high after the last bit
  task automatic frame(input logic [31:0] v, input int n, input int tail,
                       input int hold);
    select(1'b1);
    shift(v, n);
    shift(32'h0000_0000, tail);
    @(posedge sys_clk_i);
    serial_clock_o <= 1'b0;
    serial_in_o    <= ~serial_in_o;
    wait_clk(4 + hold);
    select(1'b0);
  endtask
endmodule

// file: bench/serial_eeprom_program_cmds_test.sv
`timescale 1ns/1ns
// ==========================================================================
// self-checking bench of the serial eeprom command block
module serial_eeprom_program_cmds_test;
  localparam int PROG = 300; // shortened program cycle
  logic sys_clk_i, rstn_i;   // clock and reset
  logic cs, sk, di, dout, doe; // serial pins
  int   bad_count, samples_checked;
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  serial_eeprom_program_cmds #(.PROG_CYCLES(PROG)) i_dut (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .chip_select_i(cs),
    .serial_clock_pin_i(sk), .serial_in_pin_i(di), .serial_out_o(dout),
    .serial_out_oe_o(doe));
  eeprom_host_model i_host (
    .sys_clk_i(sys_clk_i), .serial_out_i(dout), .chip_select_o(cs),
    .serial_clock_o(sk), .serial_in_o(di));
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask
  task automatic final_report;
    if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // instruction with optional data word
  task automatic cmd(input logic [1:0] opc, input logic [7:0] adr,
                     input logic [15:0] dat, input bit wd, input int hold);
    if (wd) i_host.frame({5'h00, 1'b1, opc, adr, dat}, 27, 0, hold);
    else i_host.frame({21'h00_0000, 1'b1, opc, adr}, 11, 0, hold);
  endtask
  task automatic special(input logic [1:0] spc, input logic [15:0] dat);
    cmd(eeprom_pkg::OPC_SPECIAL, {spc, 6'h00}, dat,
        spc == eeprom_pkg::SPC_BULK_FILL, 0);
  endtask
  task automatic rd(input logic [7:0] adr, input logic [15:0] exp);
    i_host.frame({21'h00_0000, 1'b1, eeprom_pkg::OPC_READ, adr}, 11, 17, 0);
    check(i_host.rx, exp, "read data");
  endtask
  // raise select again and judge the ready/busy status
  task automatic status(input logic armed);
    i_host.select(1'b1);
    if (armed) begin
      check({15'h0000, doe}, 16'h0001, "no status");
      check({15'h0000, dout}, 16'h0000, "no busy");
      for (int i = 0; i < PROG + 40 && dout !== 1'b1; i++) begin
        @(posedge sys_clk_i);
      end
      check({15'h0000, dout}, 16'h0001, "no ready");
    end else begin
      check({15'h0000, doe}, 16'h0000, "stray status");
    end
    i_host.select(1'b0);
    check({15'h0000, doe}, 16'h0000, "not released");
  endtask
  task automatic t_locked;
    cmd(eeprom_pkg::OPC_WRITE, 8'h5a, 16'h1234, 1, 0);
    status(1'b0);
  endtask
  task automatic t_write;
    special(eeprom_pkg::SPC_ENABLE, 16'h0000);
    cmd(eeprom_pkg::OPC_WRITE, 8'h5a, 16'h1234, 1, 0);
    status(1'b1);
    rd(8'h5a, 16'h1234);
  endtask
  task automatic t_disable;
    special(eeprom_pkg::SPC_DISABLE, 16'h0000);
    cmd(eeprom_pkg::OPC_WRITE, 8'h5a, 16'hbeef, 1, 0);
    status(1'b0);
    cmd(eeprom_pkg::OPC_ERASE, 8'h5a, 16'h0000, 0, 0);
    status(1'b0);
    special(eeprom_pkg::SPC_BULK_ERASE, 16'h0000);
    status(1'b0);
    special(eeprom_pkg::SPC_BULK_FILL, 16'hbeef);
    status(1'b0);
    rd(8'h5a, 16'h1234);
  endtask
  task automatic t_erase;
    special(eeprom_pkg::SPC_ENABLE, 16'h0000);
    cmd(eeprom_pkg::OPC_WRITE, 8'h5b, 16'h0001, 1, 0);
    status(1'b1);
    cmd(eeprom_pkg::OPC_ERASE, 8'h5a, 16'h0000, 0, 0);
    status(1'b1);
    rd(8'h5a, eeprom_pkg::ERASED_WORD);
    rd(8'h5b, 16'h0001);
  endtask
  task automatic t_bulk;
    special(eeprom_pkg::SPC_BULK_FILL, 16'ha5c3);
    status(1'b1);
    rd(8'h00, 16'ha5c3);
    rd(8'hff, 16'ha5c3);
    special(eeprom_pkg::SPC_BULK_ERASE, 16'h0000);
    status(1'b1);
    rd(8'h80, eeprom_pkg::ERASED_WORD);
  endtask
  task automatic t_late;
    cmd(eeprom_pkg::OPC_WRITE, 8'h33, 16'h0f0f, 1, PROG + 60);
    status(1'b0);
    rd(8'h33, 16'h0f0f);
  endtask
  // watchdog
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    bad_count++;
    final_report();
  end
  initial begin
    rstn_i = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    repeat (16) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    t_locked();
    t_write();
    t_disable();
    t_erase();
    t_bulk();
    t_late();
    special(eeprom_pkg::SPC_DISABLE, 16'h0000);
    final_report();
  end
endmodule
